/* File: rtl/fault_seq_pkg.sv */
// Constants, states and field layout for the fault latch and hiccup sequencer
// Function
// - A short-circuit or overload indication raises the fault flag and runs the timer.
// - When the timer runs past its duration, gate drive stops and supply collapses.
// - After a timer stop, the first supply turn-on is skipped; one more cycle waits.
// - Every restart after a hiccup begins with soft-start active.
// - Compensation ramp is applied only during on-time, removed during off-time.
// - Switch duty ratio is limited to 80 percent per cycle.
// - Latch detection uses the 3 V power-limit pin comparator output as raw event.
// - After each turn-off the latch comparator is ignored for 1 us.
// - A comparator high counts only if it lasts at least 600 ns.
// - Latch off only after valid events in four successive switching cycles.
// - A switching cycle without a valid event restarts the count from zero.
// - Latched: pulses stay stopped, supply clamped near 7 V until supply cycles.
// - Overload timer duration is 200 ms.
// - Short-circuit makes the timer run four times faster.
// - Fault clearing before timer completion resets the timer to zero.
package fault_seq_pkg;

    // ==========================================================
    // Clock and switching cycle
    localparam int CLK_HZ         = 50_000_000;
    localparam int SW_FREQ_HZ     = 65_000;
    localparam int PERIOD_CYCLES  = CLK_HZ / SW_FREQ_HZ;
    localparam int MAX_DUTY_PCT   = 80;
    localparam int MAX_ON_CYCLES  = PERIOD_CYCLES * MAX_DUTY_PCT / 100;

    // ==========================================================
    // Latch path timing
    localparam int BLANK_NS       = 1000;
    localparam int BLANK_CYCLES   = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MIN_WIDTH_NS   = 600;
    localparam int MIN_WIDTH_CYC  = (MIN_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int LATCH_EVENTS   = 4;

    // ==========================================================
    // Fault timer and soft-start length
    localparam int FAULT_MS       = 200;
    localparam int FAULT_CYCLES   = FAULT_MS * (CLK_HZ / 1000);
    localparam int SHORT_RATE     = 4;
    localparam int SOFT_START_DEF = 4096;

    // ==========================================================
    // Synchronised input bit positions and width
    localparam int IN_OVERLOAD    = 0;
    localparam int IN_SHORT       = 1;
    localparam int IN_TURN_ON     = 2;
    localparam int IN_SUPPLY_MIN  = 3;
    localparam int IN_LIMIT_CMP   = 4;
    localparam int IN_CS_TRIP     = 5;
    localparam int IN_WIDTH       = 6;

    typedef enum logic [2:0]
    {
        ST_STARTUP = 3'h0,
        ST_RUN     = 3'h1,
        ST_STOP1   = 3'h2,
        ST_SKIP    = 3'h3,
        ST_DRAIN2  = 3'h4,
        ST_LATCH   = 3'h5
    } seq_state_type;

    typedef struct packed
    {
        seq_state_type st;
        logic [5:0]    sync1;
        logic [5:0]    sync2;
        logic [9:0]    sw_cnt;
        logic          gate;
        logic [5:0]    blank_cnt;
        logic [4:0]    width_cnt;
        logic          evt_seen;
        logic [2:0]    evt_cnt;
        logic [24:0]   fault_timer;
        logic [15:0]   ss_cnt;
    } state_type;

endpackage

/* File: rtl/fault_latch_hiccup_sequencer.sv */
// Fault timer, double hiccup and latch-off sequencer of the PWM controller
`timescale 1ns/100ps
module fault_latch_hiccup_sequencer
#(
    parameter int FAULT_LIMIT       = fault_seq_pkg::FAULT_CYCLES,
    parameter int SOFT_START_CYCLES = fault_seq_pkg::SOFT_START_DEF
)
(
    input  wire logic i_mclk,                     // Switching oscillator clock, 50 MHz
    input  wire logic i_rst,                      // Asynchronous reset, active high
    input  wire logic i_overload,                 // Max peak current setpoint reached
    input  wire logic i_short_circuit,            // Feedback in short-circuit region
    input  wire logic i_supply_turn_on_threshold, // Supply at or above turn-on level
    input  wire logic i_supply_min,               // Supply below minimum operating level
    input  wire logic i_power_limit_pin,          // 3 V comparator output on the power-limit pin
    input  wire logic i_cs_trip,                  // Current sense reached the peak setpoint
    output logic      o_gate,                     // Gate drive
    output logic      o_ramp_connect,             // Compensation ramp to current-sense input
    output logic      o_soft_start,               // Soft-start sequence active
    output logic      o_fault_flag,               // Internal fault flag
    output logic      o_hiccup,                   // Hiccup in progress, pulses stopped
    output logic      o_latched,                  // Permanently latched off
    output logic      o_vcc_clamp                 // Supply clamp near 7 V engaged
);

    // ==========================================================
    // State
    fault_seq_pkg::state_type s;
    fault_seq_pkg::state_type next_s;

    logic       fault;
    logic       wrap;
    logic [24:0] timer_sum;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_s = s;
        // Only the second stage is looked at; first stage feeds it alone
        next_s.sync1 = {i_cs_trip, i_power_limit_pin, i_supply_min,
                        i_supply_turn_on_threshold, i_short_circuit, i_overload};
        next_s.sync2 = s.sync1;

        fault = s.sync2[fault_seq_pkg::IN_OVERLOAD] | s.sync2[fault_seq_pkg::IN_SHORT];
        wrap  = (s.sw_cnt == 10'(fault_seq_pkg::PERIOD_CYCLES - 1));
        next_s.sw_cnt = wrap ? 10'h000 : s.sw_cnt + 10'h001;
        timer_sum = s.fault_timer + (s.sync2[fault_seq_pkg::IN_SHORT] ?
                    25'(fault_seq_pkg::SHORT_RATE) : 25'h0000001);

        case (s.st)
            fault_seq_pkg::ST_STARTUP:
            begin
                next_s.gate = 1'b0;
                if (s.sync2[fault_seq_pkg::IN_TURN_ON] && !s.sync2[fault_seq_pkg::IN_SUPPLY_MIN])
                begin
                    next_s.st          = fault_seq_pkg::ST_RUN;
                    next_s.ss_cnt      = 16'(SOFT_START_CYCLES);
                    next_s.fault_timer = 25'h0000000;
                    next_s.evt_cnt     = 3'h0;
                    next_s.evt_seen    = 1'b0;
                    next_s.width_cnt   = 5'h00;
                    next_s.blank_cnt   = 6'h00;
                end
            end
            fault_seq_pkg::ST_RUN:
            begin
                if (s.ss_cnt != 16'h0000)
                begin
                    next_s.ss_cnt = s.ss_cnt - 16'h0001;
                end
                // On-time starts at count zero and ends on trip or duty limit
                if (wrap)
                begin
                    next_s.gate = 1'b1;
                end
                else if (s.sync2[fault_seq_pkg::IN_CS_TRIP] ||
                         s.sw_cnt >= 10'(fault_seq_pkg::MAX_ON_CYCLES - 1))
                begin
                    next_s.gate = 1'b0;
                end
                // Blanking after each turn-off hides the leakage spike
                if (s.gate && !next_s.gate)
                begin
                    next_s.blank_cnt = 6'(fault_seq_pkg::BLANK_CYCLES);
                end
                else if (s.blank_cnt != 6'h00)
                begin
                    next_s.blank_cnt = s.blank_cnt - 6'h01;
                end
                if (!s.gate && s.blank_cnt == 6'h00 && s.sync2[fault_seq_pkg::IN_LIMIT_CMP])
                begin
                    if (s.width_cnt != 5'(fault_seq_pkg::MIN_WIDTH_CYC))
                    begin
                        next_s.width_cnt = s.width_cnt + 5'h01;
                    end
                    if (s.width_cnt == 5'(fault_seq_pkg::MIN_WIDTH_CYC - 1))
                    begin
                        next_s.evt_seen = 1'b1;
                    end
                end
                else
                begin
                    next_s.width_cnt = 5'h00;
                end
                if (wrap)
                begin
                    next_s.evt_seen  = 1'b0;
                    next_s.width_cnt = 5'h00;
                    if (s.evt_seen)
                    begin
                        next_s.evt_cnt = s.evt_cnt + 3'h1;
                        if (s.evt_cnt == 3'(fault_seq_pkg::LATCH_EVENTS - 1))
                        begin
                            next_s.st   = fault_seq_pkg::ST_LATCH;
                            next_s.gate = 1'b0;
                        end
                    end
                    else
                    begin
                        next_s.evt_cnt = 3'h0;
                    end
                end
                // Fault timer; expiry stops pulses and starts the double hiccup
                if (fault)
                begin
                    if (timer_sum >= 25'(FAULT_LIMIT))
                    begin
                        next_s.fault_timer = 25'h0000000;
                        next_s.st          = fault_seq_pkg::ST_STOP1;
                        next_s.gate        = 1'b0;
                    end
                    else
                    begin
                        next_s.fault_timer = timer_sum;
                    end
                end
                else
                begin
                    next_s.fault_timer = 25'h0000000;
                end
                if (s.sync2[fault_seq_pkg::IN_SUPPLY_MIN])
                begin
                    next_s.st   = fault_seq_pkg::ST_STARTUP;
                    next_s.gate = 1'b0;
                end
            end
            fault_seq_pkg::ST_STOP1:
            begin
                next_s.gate = 1'b0;
                if (s.sync2[fault_seq_pkg::IN_SUPPLY_MIN])
                begin
                    next_s.st = fault_seq_pkg::ST_SKIP;
                end
            end
            fault_seq_pkg::ST_SKIP:
            begin
                // First turn-on after the stop is deliberately ignored
                next_s.gate = 1'b0;
                if (s.sync2[fault_seq_pkg::IN_TURN_ON] && !s.sync2[fault_seq_pkg::IN_SUPPLY_MIN])
                begin
                    next_s.st = fault_seq_pkg::ST_DRAIN2;
                end
            end
            fault_seq_pkg::ST_DRAIN2:
            begin
                next_s.gate = 1'b0;
                if (s.sync2[fault_seq_pkg::IN_SUPPLY_MIN])
                begin
                    next_s.st = fault_seq_pkg::ST_STARTUP;
                end
            end
            fault_seq_pkg::ST_LATCH:
            begin
                // Clamp holds the supply above minimum; only removal of power releases
                next_s.gate = 1'b0;
                if (s.sync2[fault_seq_pkg::IN_SUPPLY_MIN])
                begin
                    next_s.st = fault_seq_pkg::ST_STARTUP;
                end
            end
            default:
            begin
                next_s.st   = fault_seq_pkg::ST_STARTUP;
                next_s.gate = 1'b0;
            end
        endcase
        if (next_s.st != fault_seq_pkg::ST_RUN)
        begin
            next_s.blank_cnt = 6'h00;
            next_s.width_cnt = 5'h00;
            next_s.evt_seen  = 1'b0;
            next_s.evt_cnt   = 3'h0;
            next_s.ss_cnt    = 16'h0000;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s <= '{st: fault_seq_pkg::ST_STARTUP, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign o_gate         = s.gate;
    assign o_ramp_connect = s.gate;
    assign o_soft_start   = (s.st == fault_seq_pkg::ST_RUN) && (s.ss_cnt != 16'h0000);
    assign o_fault_flag   = (s.st == fault_seq_pkg::ST_RUN) && fault;
    assign o_hiccup       = (s.st == fault_seq_pkg::ST_STOP1) || (s.st == fault_seq_pkg::ST_SKIP) ||
                            (s.st == fault_seq_pkg::ST_DRAIN2);
    assign o_latched      = (s.st == fault_seq_pkg::ST_LATCH);
    assign o_vcc_clamp    = (s.st == fault_seq_pkg::ST_LATCH);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    duty_limit_a: assert property (o_gate |-> s.sw_cnt < 10'(fault_seq_pkg::MAX_ON_CYCLES))
        else $error("gate high beyond duty limit");
    ramp_offtime_a: assert property (!o_gate |-> !o_ramp_connect)
        else $error("ramp applied during off-time");
    fault_flag_a: assert property ((s.st == fault_seq_pkg::ST_RUN && fault) |-> o_fault_flag)
        else $error("fault flag missing");
    timer_stop_a: assert property ((s.st == fault_seq_pkg::ST_RUN && fault && timer_sum >= 25'(FAULT_LIMIT)
        && !s.sync2[fault_seq_pkg::IN_SUPPLY_MIN]) |=> o_hiccup && !o_gate)
        else $error("timer expiry did not stop pulses");
    timer_clear_a: assert property ((s.st == fault_seq_pkg::ST_RUN && !fault) |=> s.fault_timer == 25'h0)
        else $error("timer not cleared");
    timer_fast_a: assert property ((s.st == fault_seq_pkg::ST_RUN && s.sync2[fault_seq_pkg::IN_SHORT]
        && next_s.st == fault_seq_pkg::ST_RUN) |=> s.fault_timer == $past(s.fault_timer) + 25'h4)
        else $error("short-circuit rate wrong");
    skip_restart_a: assert property ((s.st == fault_seq_pkg::ST_SKIP) |-> !o_gate && !o_soft_start)
        else $error("restart not skipped");
    soft_start_a: assert property ($rose(s.st == fault_seq_pkg::ST_RUN) && SOFT_START_CYCLES > 0 |-> o_soft_start)
        else $error("restart without soft-start");
    blank_event_a: assert property ($rose(s.evt_seen) |-> $past(s.blank_cnt) == 6'h00 && !$past(s.gate))
        else $error("event taken during blanking");
    min_width_a: assert property ($rose(s.evt_seen) |-> $past(s.sync2[fault_seq_pkg::IN_LIMIT_CMP])
        && $past(s.width_cnt) == 5'(fault_seq_pkg::MIN_WIDTH_CYC - 1))
        else $error("event shorter than minimum width");
    latch_count_a: assert property ($rose(o_latched) |-> $past(s.evt_cnt) == 3'(fault_seq_pkg::LATCH_EVENTS - 1))
        else $error("latched with too few events");
    count_reset_a: assert property ((wrap && s.st == fault_seq_pkg::ST_RUN && !s.evt_seen) |=> s.evt_cnt == 3'h0)
        else $error("event count not restarted");
    latch_hold_a: assert property (o_latched && !s.sync2[fault_seq_pkg::IN_SUPPLY_MIN] |=> o_latched
        && o_vcc_clamp && !o_gate)
        else $error("latch released early");

    run_c: cover property (s.st == fault_seq_pkg::ST_RUN ##1 o_gate);
    hiccup_c: cover property (s.st == fault_seq_pkg::ST_SKIP ##1 s.st == fault_seq_pkg::ST_DRAIN2);
    latch_c: cover property ($rose(o_latched));
    event_c: cover property ($rose(s.evt_seen));

endmodule

/* File: sim/supply_stage_model.sv */
// Behavioural supply, current-sense and power-limit network beside the sequencer
`timescale 1ns/100ps
module supply_stage_model
(
    input  wire logic       i_mclk,       // Oscillator clock
    input  wire logic       i_rst,        // Reset, active high
    input  wire logic       i_gate,       // Gate drive from the sequencer
    input  wire logic       i_hiccup,     // Pulses stopped by the fault timer
    input  wire logic       i_latched,    // Sequencer latched off
    input  wire logic       i_unplug,     // Mains removed
    input  wire logic [9:0] i_cs_on,      // On cycles until current trip, 0 never
    input  wire logic [9:0] i_ovp_start,  // Pin rise, cycles after turn-off
    input  wire logic [9:0] i_ovp_width,  // Pin high cycles, 0 never
    output logic            o_turn_on,    // Supply at turn-on level
    output logic            o_supply_min, // Supply at minimum level
    output logic            o_cs_trip,    // Current sense trip
    output logic            o_limit_pin   // Power-limit comparator output
);
    // ==========================================
    // Supply level: charges through the start-up network, drains during hiccup, held at the clamp level while latched
    localparam logic [6:0] LO = 7'h08;
    localparam logic [6:0] HI = 7'h38;
    logic [6:0] vcc;
    logic [1:0] dir;
    logic [9:0] on_cnt;
    logic [9:0] off_cnt;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            vcc <= 7'h00;
            dir <= 2'h1;
            on_cnt <= 10'h000;
            off_cnt <= 10'h000;
        end
        else
        begin
            on_cnt <= i_gate ? on_cnt + 10'h001 : 10'h000;
            off_cnt <= i_gate ? 10'h000 : (off_cnt == 10'h3ff ? off_cnt : off_cnt + 10'h001);
            if (i_unplug)
            begin
                vcc <= (vcc == 7'h00) ? vcc : vcc - 7'h01;
                dir <= 2'h1;
            end
            else if (i_latched)
                vcc <= 7'h20;
            else if (dir == 2'h1)
            begin
                if (vcc >= HI)
                    dir <= 2'h0;
                else
                    vcc <= vcc + 7'h01;
            end
            else if (dir == 2'h2)
            begin
                if (vcc <= LO)
                    dir <= 2'h1;
                else
                    vcc <= vcc - 7'h01;
            end
            else if (i_hiccup)
                dir <= 2'h2;
        end
    end

    // Minimum level spans a few cycles so the two-flop synchroniser cannot miss it
    assign o_turn_on = (vcc >= HI);
    assign o_supply_min = (vcc <= LO + 7'h02);
    assign o_cs_trip = (i_cs_on != 10'h000) && (on_cnt >= i_cs_on);
    assign o_limit_pin = (i_ovp_width != 10'h000) && (off_cnt >= i_ovp_start)
                         && (off_cnt - i_ovp_start < i_ovp_width);
endmodule

/* File: sim/fault_latch_hiccup_sequencer_tb_top.sv */
// Self-checking bench for the fault latch and hiccup sequencer
`timescale 1ns/100ps
module fault_latch_hiccup_sequencer_tb_top;
    localparam int FL = 200;
    localparam int SS = 16;
    localparam int EV_HIC = 1;
    localparam int EV_SS = 2;
    localparam int EV_LAT = 3;
    localparam int EV_UNL = 4;
    localparam int EV_ON = 5;
    logic i_mclk, i_rst, i_overload, i_short_circuit, turn_on, supply_min, cs_trip, limit_pin, unplug;
    logic o_gate, o_ramp_connect, o_soft_start, o_fault_flag, o_hiccup, o_latched, o_vcc_clamp;
    logic [9:0]  cs_on, ovp_start, ovp_width;
    logic [4:0]  now;
    logic [4:0]  was = 5'h08;
    logic [31:0] seed = 32'h8c6f99fe;
    int          errors = 0;
    int          total_checks = 0;
    int          q[$];

    fault_latch_hiccup_sequencer #(.FAULT_LIMIT(FL), .SOFT_START_CYCLES(SS)) uut (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_overload(i_overload), .i_short_circuit(i_short_circuit),
        .i_supply_turn_on_threshold(turn_on), .i_supply_min(supply_min), .i_power_limit_pin(limit_pin),
        .i_cs_trip(cs_trip), .o_gate(o_gate), .o_ramp_connect(o_ramp_connect), .o_soft_start(o_soft_start),
        .o_fault_flag(o_fault_flag), .o_hiccup(o_hiccup), .o_latched(o_latched), .o_vcc_clamp(o_vcc_clamp));
    supply_stage_model model (.i_mclk(i_mclk), .i_rst(i_rst), .i_gate(o_gate), .i_hiccup(o_hiccup),
        .i_latched(o_latched), .i_unplug(unplug), .i_cs_on(cs_on), .i_ovp_start(ovp_start),
        .i_ovp_width(ovp_width), .o_turn_on(turn_on), .o_supply_min(supply_min), .o_cs_trip(cs_trip),
        .o_limit_pin(limit_pin));

    // ==========================================
    // Clock, checks and closing report
    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tick();
        @(posedge i_mclk);
        #2;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: output %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("wrong value at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic check_event(input int got);
        int e;
        total_checks++;
        e = (q.size() == 0) ? 0 : q.pop_front();
        if (e != got)
        begin
            errors++;
            $display("wrong value at %0t: event %0d, expected %0d", $time, got, e);
        end
    endtask

    task automatic wait_q(input int n);
        for (int k = 0; k < n && q.size() != 0; k++) tick();
        check_count(q.size(), 0, 0);
    endtask

    // One switching period; window settings take effect in this period's off-time
    task automatic pulse(input int s, input int wd, output int w);
        for (int k = 0; k < 2000 && o_gate !== 0; k++) tick();
        for (int k = 0; k < 2000 && o_gate !== 1; k++) tick();
        ovp_start = s[9:0];
        ovp_width = wd[9:0];
        check_bit(o_ramp_connect, 1'b1);
        for (w = 0; w < 2000 && o_gate === 1; w++) tick();
        check_bit(o_ramp_connect, 1'b0);
    endtask

    task automatic results();
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Status edges are compared in order against the notes left by the driver
    always @(posedge i_mclk)
    begin
        #1;
        if (i_rst === 1'b0)
        begin
            now = {turn_on, ~o_latched, o_latched, o_soft_start, o_hiccup};
            for (int i = 0; i < 5; i++)
                if (now[i] === 1'b1 && was[i] !== 1'b1)
                    check_event(i + 1);
            was = now;
            if (o_hiccup === 1'b1 || o_latched === 1'b1)
                check_bit(o_gate, 1'b0);
            check_bit(o_vcc_clamp, o_latched);
        end
    end

    initial
    begin
        for (int cycles = 0; cycles < 40000; cycles++) @(posedge i_mclk);
        errors++;
        results();
    end

    // ==========================================
    // Main sequence
    initial
    begin
        int n, w, r;
        {i_rst, i_overload, i_short_circuit, unplug} = 4'h8;
        {cs_on, ovp_start, ovp_width} = 30'h0;
        repeat (20) @(posedge i_mclk);
        #2;
        i_rst = 1'b0;
        q = {EV_ON, EV_SS};
        wait_q(400);
        pulse(0, 0, w);
        pulse(0, 0, w);
        check_count(w, 615, 615);
        for (n = 0; n < 3; n++)
        begin
            r = 50 + int'(rnd() % 400);
            cs_on = r[9:0];
            pulse(0, 0, w);
            check_count(w, r + 1, r + 6);
        end
        cs_on = 10'h000;
        for (n = 0; n < 3; n++)
        begin
            i_overload = 1'b1;
            repeat (70 + int'(rnd() % 30)) tick();
            check_bit(o_fault_flag, 1'b1);
            i_overload = 1'b0;
            repeat (5) tick();
        end
        check_bit(o_hiccup, 1'b0);
        for (r = 0; r < 2; r++)
        begin
            q = {EV_HIC, EV_ON, EV_ON, EV_SS};
            i_overload = (r == 0);
            i_short_circuit = (r == 1);
            for (n = 0; n < 100 && o_fault_flag !== 1; n++) tick();
            for (n = 0; n < 1000 && o_hiccup !== 1; n++) tick();
            check_count(n, (r ? FL / 4 : FL) - 2, (r ? FL / 4 : FL) + 2);
            i_overload = 1'b0;
            i_short_circuit = 1'b0;
            wait_q(1500);
        end
        for (n = 0; n < 4; n++) pulse(5, 36, w);
        for (n = 0; n < 4; n++) pulse(100, 25, w);
        for (n = 0; n < 7; n++) pulse(100, n == 3 ? 25 : 40, w);
        pulse(0, 0, w);
        q = {EV_LAT};
        for (n = 0; n < 4; n++) pulse(100, 40, w);
        // The fourth event lies in the off-time after the last pulse returns; keep its window open
        repeat (200) tick();
        ovp_width = 10'h000;
        wait_q(1600);
        i_overload = 1'b1;
        repeat (800) tick();
        check_bit(o_latched, 1'b1);
        i_overload = 1'b0;
        q = {EV_UNL};
        unplug = 1'b1;
        wait_q(300);
        unplug = 1'b0;
        q = {EV_ON, EV_SS};
        wait_q(400);
        results();
    end
endmodule
